/* design/crs_pkg.sv */
// constants, field layout and types of the configuration bank with nonvolatile shadow
package crs_pkg;

  // ------------------------------------------------------------
  // serial frame layout
  // ------------------------------------------------------------
  localparam int unsigned FRAME_BITS  = 32;
  localparam int unsigned DATA_BITS   = 28;
  localparam int unsigned ADDR_BITS   = 4;
  localparam int unsigned ADDR_LSB    = 28;
  localparam int unsigned CNT_BITS    = 6;
  localparam logic [5:0]  CNT_FULL    = 6'h20;
  localparam logic [5:0]  CNT_FIRST   = 6'h01;

  // ------------------------------------------------------------
  // register addresses and commands
  // ------------------------------------------------------------
  localparam int unsigned NUM_NVM_REGS = 8;
  localparam int unsigned NVM_IDX_BITS = 3;
  localparam logic [2:0]  NVM_LAST_IDX = 3'h7;
  localparam int unsigned NVM_TOTAL_BITS = 184;
  localparam logic [3:0]  ADDR_IN_OUT0_CONFIG = 4'h0;
  localparam logic [3:0]  ADDR_LAST_NVM       = 4'h7;
  localparam logic [3:0]  ADDR_READ_CMD       = 4'hE;
  localparam logic [3:0]  ADDR_COPY_CMD       = 4'hF;
  localparam logic [27:0] COPY_UNLOCK_DATA    = 28'h0000001;
  localparam logic [27:0] COPY_LOCK_DATA      = 28'h0000A03;

  // ------------------------------------------------------------
  // register 0 field positions
  // ------------------------------------------------------------
  localparam int unsigned PREDIV_LSB  = 0;
  localparam int unsigned SRCSEL_LSB  = 4;
  localparam int unsigned PHASE_LSB   = 6;
  localparam int unsigned PHASE_BITS  = 6;
  localparam logic [1:0]  PREDIV_HIZ  = 2'h0;
  localparam logic [1:0]  PREDIV_DIV1 = 2'h1;
  localparam logic [1:0]  PREDIV_DIV2 = 2'h2;
  localparam logic [1:0]  SRC_PRIMARY_REFERENCE   = 2'h0;
  localparam logic [1:0]  SRC_SECONDARY_REFERENCE = 2'h1;
  localparam logic [1:0]  SRC_AUTO_SELECTOR       = 2'h2;
  localparam logic [1:0]  SRC_OSCILLATOR_CORE     = 2'h3;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ      = 25000000;
  localparam int unsigned NVM_WRITE_TIME_MS = 50;
  localparam int unsigned NVM_WRITE_CYCLES =
    (NVM_WRITE_TIME_MS * (CLK_FREQ_HZ / 1000));

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0] out0_coarse_phase;
    logic [1:0] out0_source_sel;
    logic [1:0] primary_prediv_sel;
  } crs_cfg0_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [27:0] data;
  } crs_frame_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_IDLE = 2'b01,
    ST_COPY = 2'b10,
    ST_WAIT = 2'b11
  } crs_state_t;

endpackage

/* design/crs_config_bank.sv */
// configuration register bank with serial access and nonvolatile shadow copy
//
// How it works
// - after reset, all eight registers are loaded from the nonvolatile memory
// - a copy command writes registers 0 to 7, 224 bits, into nonvolatile memory
// - the unlocked copy command runs any number of times while unlocked
// - the locking copy runs once, then locks memory against every later copy
// - register address zero selects the input and output 0 configuration register
// - register 0 bits 1:0 pick primary pre-divider: hi-z, divide 1, divide 2
// - register 0 bits 5:4 pick output divider 0 source among four clocks
// - register 0 bits 6 upward hold the output 0 coarse phase field
// - each frame is 32 bits LSB first: 28 data bits, then 4 address bits
// - locked memory still allows register writes but never changes stored contents
`timescale 1ns/1ns
`default_nettype none

module crs_config_bank
  import crs_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = NVM_WRITE_CYCLES
)
(
  // system clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // serial link, clocked by the host
  input  wire logic        spi_clk_in,
  input  wire logic        spi_le_in,
  input  wire logic        spi_mosi_in,
  output logic             spi_miso_out,
  // nonvolatile memory macro
  output logic [2:0]       nvm_addr_out,
  input  wire logic [27:0] nvm_rdata_in,
  output logic [27:0]      nvm_wdata_out,
  output logic             nvm_we_out,
  input  wire logic        nvm_locked_in,
  output logic             nvm_lock_set_out,
  // configuration and status
  output crs_cfg0_t        cfg0_out,
  output logic             nvm_busy_out,
  output logic             nvm_locked_out
);

  // ------------------------------------------------------------
  // link domain: shift in on rising edge, shift out on falling edge
  // ------------------------------------------------------------
  logic [31:0] shift_in_reg;
  logic [5:0]  bit_cnt_reg;
  logic [31:0] shift_out_reg;
  logic [31:0] readback_reg;
  logic        armed_reg;

  // latch enable high only arms the counter; clearing the count itself would erase it before the system side judges it
  always_ff @(posedge spi_clk_in or posedge spi_le_in)
  begin
    if (spi_le_in)
      armed_reg <= 1'b1;
    else
      armed_reg <= 1'b0;
  end

  // stops one past 32, so long frames are refused as well as short ones
  always_ff @(posedge spi_clk_in)
  begin
    if (armed_reg)
      bit_cnt_reg <= CNT_FIRST;
    else if (bit_cnt_reg <= CNT_FULL)
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
  end

  always_ff @(posedge spi_clk_in)
  begin
    shift_in_reg <= {spi_mosi_in, shift_in_reg[31:1]};
  end

  // readback_reg only changes at the end of a frame, long before the next one drives data out
  always_ff @(negedge spi_clk_in)
  begin
    if (bit_cnt_reg == CNT_FIRST)
      shift_out_reg <= readback_reg;
    else
      shift_out_reg <= {1'b0, shift_out_reg[31:1]};
  end

  assign spi_miso_out = shift_out_reg[0];

  // ------------------------------------------------------------
  // frame end detection in the system domain
  // ------------------------------------------------------------
  logic le_s1_reg;
  logic le_s2_reg;
  logic le_s3_reg;
  logic frame_end;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      le_s1_reg <= 1'b1;
      le_s2_reg <= 1'b1;
      le_s3_reg <= 1'b1;
    end
    else
    begin
      le_s1_reg <= spi_le_in;
      le_s2_reg <= le_s1_reg;
      le_s3_reg <= le_s2_reg;
    end
  end

  // shift_in_reg and bit_cnt_reg are still while latch enable stays high
  assign frame_end = le_s2_reg && !le_s3_reg;

  crs_frame_t frame;
  logic       frame_ok;
  assign frame    = crs_frame_t'(shift_in_reg);
  assign frame_ok = frame_end && (bit_cnt_reg == CNT_FULL);

  // ------------------------------------------------------------
  // sequencer: load, idle, copy, write-cycle wait
  // ------------------------------------------------------------
  crs_state_t  state_reg;
  logic [2:0]  idx_reg;
  logic [31:0] wait_cnt_reg;
  logic        lock_pending_reg;
  logic        locked_reg;
  logic [27:0] regs_reg [NUM_NVM_REGS];
  logic        is_copy;
  logic        is_lock_cmd;
  logic        copy_allowed;

  assign is_copy     = frame_ok && (frame.addr == ADDR_COPY_CMD) &&
                       ((frame.data == COPY_UNLOCK_DATA) || (frame.data == COPY_LOCK_DATA));
  assign is_lock_cmd = frame.data == COPY_LOCK_DATA;
  assign copy_allowed = !locked_reg;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg        <= ST_LOAD;
      idx_reg          <= 3'h0;
      wait_cnt_reg     <= 32'h00000000;
      lock_pending_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_LOAD:
        begin
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == NVM_LAST_IDX)
            state_reg <= ST_IDLE;
        end
        ST_IDLE:
        begin
          if (is_copy && copy_allowed)
          begin
            state_reg        <= ST_COPY;
            idx_reg          <= 3'h0;
            lock_pending_reg <= is_lock_cmd;
          end
        end
        ST_COPY:
        begin
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == NVM_LAST_IDX)
          begin
            state_reg    <= ST_WAIT;
            wait_cnt_reg <= 32'h00000000;
          end
        end
        ST_WAIT:
        begin
          // frames during the write cycle are dropped
          wait_cnt_reg <= wait_cnt_reg + 32'h00000001;
          if (wait_cnt_reg == 32'(WRITE_CYCLES - 1))
          begin
            state_reg        <= ST_IDLE;
            lock_pending_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // permanent lock: taken from the memory at load, set by the locking copy
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      locked_reg <= 1'b0;
    else if (state_reg == ST_LOAD && idx_reg == 3'h0)
      locked_reg <= nvm_locked_in;
    else if (state_reg == ST_COPY && idx_reg == NVM_LAST_IDX && lock_pending_reg)
      locked_reg <= 1'b1;
  end

  // ------------------------------------------------------------
  // register bank and readback
  // ------------------------------------------------------------
  logic [2:0] rd_idx;
  assign rd_idx = frame.data[NVM_IDX_BITS-1:0];

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < NUM_NVM_REGS; i++)
        regs_reg[i] <= 28'h0000000;
      readback_reg <= 32'h00000000;
    end
    else if (state_reg == ST_LOAD)
      regs_reg[idx_reg] <= nvm_rdata_in;
    else if (state_reg == ST_IDLE && frame_ok)
    begin
      // writes stay open after locking, only the stored copy is frozen
      if (frame.addr <= ADDR_LAST_NVM)
        regs_reg[frame.addr[2:0]] <= frame.data;
      else if (frame.addr == ADDR_READ_CMD && frame.data[3] == 1'b0)
        readback_reg <= {{1'b0, rd_idx}, regs_reg[rd_idx]};
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      nvm_we_out       <= 1'b0;
      nvm_wdata_out    <= 28'h0000000;
      nvm_lock_set_out <= 1'b0;
    end
    else
    begin
      nvm_we_out       <= state_reg == ST_COPY;
      nvm_wdata_out    <= regs_reg[idx_reg];
      nvm_lock_set_out <= state_reg == ST_COPY && idx_reg == NVM_LAST_IDX && lock_pending_reg;
    end
  end

  // address is registered in the same cycle as write data; memory captures on the registered strobe
  logic [2:0] nvm_addr_reg;
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      nvm_addr_reg <= 3'h0;
    else
      nvm_addr_reg <= idx_reg;
  end

  assign nvm_addr_out   = (state_reg == ST_LOAD) ? idx_reg : nvm_addr_reg;
  assign nvm_busy_out   = state_reg != ST_IDLE;
  assign nvm_locked_out = locked_reg;

  // 11 is reserved for the pre-divider and passed on unchanged
  assign cfg0_out.primary_prediv_sel = regs_reg[0][PREDIV_LSB +: 2];
  assign cfg0_out.out0_source_sel    = regs_reg[0][SRCSEL_LSB +: 2];
  assign cfg0_out.out0_coarse_phase  = regs_reg[0][PHASE_LSB +: PHASE_BITS];

endmodule

`default_nettype wire

/* sim/crs_config_bank_properties.sv */
// checker for the configuration bank with nonvolatile shadow
`timescale 1ns/1ns
`default_nettype none
module crs_config_bank_properties
#(
  parameter int unsigned WRITE_CYCLES = 20
)
(
  // clock and reset
  input wire logic       clock_in,
  input wire logic       rst_n_in,
  // memory side and status
  input wire logic [2:0] nvm_addr_out,
  input wire logic       nvm_we_out,
  input wire logic       nvm_lock_set_out,
  input wire logic       nvm_busy_out,
  input wire logic       nvm_locked_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_we_busy;
    nvm_we_out |-> nvm_busy_out;
  endproperty
  a_we_busy: assert property (p_we_busy) else $error("write strobe outside busy");
  property p_eight_words;
    $rose(nvm_we_out) |-> nvm_addr_out == 3'h0 ##0 nvm_we_out[*8] ##1 !nvm_we_out;
  endproperty
  a_eight_words: assert property (p_eight_words) else $error("copy not eight words from 0");
  property p_addr_step;
    nvm_we_out && $past(nvm_we_out) |-> nvm_addr_out == $past(nvm_addr_out) + 3'h1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("word index did not step");
  property p_lock_last;
    nvm_lock_set_out |-> nvm_we_out && nvm_addr_out == 3'h7;
  endproperty
  a_lock_last: assert property (p_lock_last) else $error("lock pulse off last word");
  property p_lock_flag;
    nvm_lock_set_out |=> nvm_locked_out;
  endproperty
  a_lock_flag: assert property (p_lock_flag) else $error("lock flag not set");
  property p_lock_sticky;
    nvm_locked_out |=> nvm_locked_out;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock flag dropped");
  property p_no_copy_locked;
    nvm_locked_out |-> !$rose(nvm_we_out);
  endproperty
  a_no_copy_locked: assert property (p_no_copy_locked) else $error("copy while locked");
  property p_wait_busy;
    $fell(nvm_we_out) |-> nvm_busy_out[*8];
  endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("busy fell early");
  // ----------------------------------------
  // write cycle length
  // ----------------------------------------
  logic [31:0] wait_run_reg;
  logic        copy_seen_reg;
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wait_run_reg  <= 32'h00000000;
      copy_seen_reg <= 1'b0;
    end
    else
    begin
      if (nvm_busy_out && !nvm_we_out)
        wait_run_reg <= wait_run_reg + 32'h00000001;
      else
        wait_run_reg <= 32'h00000000;
      if (nvm_we_out)
        copy_seen_reg <= 1'b1;
      else if (!nvm_busy_out)
        copy_seen_reg <= 1'b0;
    end
  end
  property p_wait_len;
    $fell(nvm_busy_out) && copy_seen_reg |-> wait_run_reg == 32'(WRITE_CYCLES - 1);
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("write cycle length off");
  c_lock: cover property (nvm_lock_set_out);
  c_copy: cover property ($fell(nvm_we_out));
  c_idle: cover property ($fell(nvm_busy_out));
endmodule
bind crs_config_bank crs_config_bank_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .nvm_addr_out(nvm_addr_out), .nvm_we_out(nvm_we_out),
  .nvm_lock_set_out(nvm_lock_set_out), .nvm_busy_out(nvm_busy_out), .nvm_locked_out(nvm_locked_out));
`default_nettype wire

/* sim/crs_host_model.sv */
// serial host model driving frames into the bank
`timescale 1ns/1ns
`default_nettype none
module crs_host_model (
  // link pins
  output var logic  spi_clk_out,
  output var logic  spi_le_out,
  output var logic  spi_mosi_out,
  input  wire logic spi_miso_in
);
  logic [31:0] rx;
  initial
  begin
    spi_clk_out = 1'b0;
    spi_le_out = 1'b0;
    spi_mosi_out = 1'b0;
    // one rising latch enable arms the frame counter before the first frame
    #1 spi_le_out = 1'b1;
  end
  // clock parked low between frames; mosi flips after release
  task automatic frame(input logic [31:0] f, input int n);
    #3 spi_le_out = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      spi_mosi_out = (i < 32) ? f[i] : 1'b0;
      #7 spi_clk_out = 1'b1;
      rx[i] = spi_miso_in;
      #8 spi_clk_out = 1'b0;
    end
    #8 spi_le_out = 1'b1;
    spi_mosi_out = ~spi_mosi_out;
  endtask
endmodule
`default_nettype wire

/* sim/crs_config_bank_tb_top.sv */
// testbench for the configuration bank with nonvolatile shadow
`timescale 1ns/1ns
`default_nettype none
module crs_config_bank_tb_top;
  import crs_pkg::*;
  logic        clock_in, rst_n_in, spi_clk, spi_le, spi_mosi, spi_miso;
  logic [2:0]  nvm_addr;
  logic [27:0] nvm_wdata, d, rd_val;
  logic        nvm_we, nvm_lock_set, nvm_busy, nvm_locked, stored_lock;
  logic [27:0] mem [8];
  crs_cfg0_t   cfg0;
  logic [31:0] seed;
  int          fails, samples_checked, we_cnt, base;
  crs_host_model u_host (.spi_clk_out(spi_clk), .spi_le_out(spi_le), .spi_mosi_out(spi_mosi),
    .spi_miso_in(spi_miso));
  crs_config_bank #(.WRITE_CYCLES(20)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .spi_clk_in(spi_clk), .spi_le_in(spi_le), .spi_mosi_in(spi_mosi), .spi_miso_out(spi_miso),
    .nvm_addr_out(nvm_addr), .nvm_rdata_in(mem[nvm_addr]), .nvm_wdata_out(nvm_wdata),
    .nvm_we_out(nvm_we), .nvm_locked_in(stored_lock), .nvm_lock_set_out(nvm_lock_set),
    .cfg0_out(cfg0), .nvm_busy_out(nvm_busy), .nvm_locked_out(nvm_locked));
  // ----------------------------------------
  // memory model and clock
  // ----------------------------------------
  always @(posedge clock_in)
  begin
    if (nvm_we) mem[nvm_addr] <= nvm_wdata;
    if (nvm_we) we_cnt <= we_cnt + 1;
    if (nvm_lock_set) stored_lock <= 1'b1;
  end
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic crs_cfg0_t exp_cfg(input logic [27:0] v);
    return {v[11:6], v[5:4], v[1:0]};
  endfunction
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic send(input logic [3:0] a, input logic [27:0] v);
    u_host.frame({a, v}, 32);
    repeat (6) @(posedge clock_in);
  endtask
  // idle wait keeps the host silent through the rest of the write cycle
  task automatic wait_idle();
    for (int i = 0; i < 200 && nvm_busy !== 1'b0; i++) @(posedge clock_in);
    repeat (9) @(posedge clock_in);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    #200000;
    fails++;
    close_out();
  end
  initial
  begin
    seed = 32'hE40EA6D3;
    rst_n_in = 1'b0;
    stored_lock = 1'b0;
    we_cnt = 0;
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      mem[i] = seed[27:0];
    end
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    wait_idle();
    check("load", exp_cfg(mem[0]), cfg0);
    check("unlocked", 0, nvm_locked);
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      d = {seed[27:6], k[1:0], 2'h0, k[1:0]};
      send(ADDR_IN_OUT0_CONFIG, d);
      check("cfg0", exp_cfg(d), cfg0);
    end
    // a frame one bit short or one bit long must leave the register alone
    for (int n = 31; n <= 33; n += 2)
    begin
      u_host.frame({ADDR_IN_OUT0_CONFIG, ~d}, n);
      repeat (6) @(posedge clock_in);
      check("cfg0 length", exp_cfg(d), cfg0);
    end
    // answer bit k reaches the host at its rising edge k+2, so the top bit stays unseen
    seed = lfsr(seed);
    rd_val = seed[27:0];
    send(4'h3, rd_val);
    send(ADDR_READ_CMD, 28'h0000003);
    send(ADDR_READ_CMD, 28'h0000003);
    check("readback", {1'b0, 3'h3, rd_val}, {1'b0, u_host.rx[31:1]});
    for (int r = 0; r < 3; r++)
    begin
      seed = lfsr(seed);
      d = seed[27:0];
      base = we_cnt;
      send(ADDR_IN_OUT0_CONFIG, d);
      send(ADDR_COPY_CMD, (r == 2) ? COPY_LOCK_DATA : COPY_UNLOCK_DATA);
      send(ADDR_IN_OUT0_CONFIG, ~d);
      wait_idle();
      check("cfg0 busy", exp_cfg(d), cfg0);
      check("nvm word0", d, mem[0]);
      check("words", 8, we_cnt - base);
    end
    check("locked", 1, nvm_locked);
    seed = lfsr(seed);
    base = we_cnt;
    send(ADDR_IN_OUT0_CONFIG, seed[27:0]);
    check("cfg0 locked", exp_cfg(seed[27:0]), cfg0);
    send(ADDR_COPY_CMD, COPY_UNLOCK_DATA);
    wait_idle();
    check("nvm kept", d, mem[0]);
    check("no words", 0, we_cnt - base);
    // second reset: bank contents and lock come back from the memory
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    wait_idle();
    check("reload", exp_cfg(d), cfg0);
    check("lock reload", 1, nvm_locked);
    close_out();
  end
endmodule
`default_nettype wire
